//--- common/ddmss_cfg.svh
// Constants for the dual-die memory side-signal block
`ifndef DDMSS_CFG_SVH
`define DDMSS_CFG_SVH

// Command-address phase length in bytes, one byte per link clock edge
`define DDMSS_CA_BYTES      3'h6
// Read/write bit position inside the command-address word (1 = read)
`define DDMSS_CA_RD_BIT     47
// Default initial latency in link clock cycles
`define DDMSS_LAT_CLKS      6
// Reset value of the release-delay register; por_timeout replaces it in the first enabled cycle, before counting starts
`define DDMSS_POR_HOLD_DEF  16'h0040
// Reset value of the synchronised hardware reset pin (inactive high)
`define DDMSS_PIN_IDLE_HI   1'b1

`endif

//--- common/ddmss_pkg.sv
// Types shared by the dual-die memory side-signal block
package ddmss_pkg;

  // Transaction sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CA,
    ST_LAT,
    ST_DATA
  } ddmss_state_t;

  // Which die a transaction addresses
  typedef enum logic {
    DIE_FLASH,
    DIE_DRAM
  } ddmss_die_t;

endpackage : ddmss_pkg

//--- hw/ddmss_side.sv
// Side signals and chip-select sharing of a flash plus DRAM two-die package
`timescale 1ns/1ps
`include "ddmss_cfg.svh"

// Functional notes
// - The eight data lines carry both command-address bytes and data bytes of each transaction.
// - The flash die pulls the event output low when an internal event such as busy-to-ready occurs.
// - The event output is open-drain, only ever driven low and otherwise released.
// - A low hardware reset returns the flash side to idle and abandons its transaction.
// - While hardware reset is low the flash die releases the strobe and all data lines to high impedance.
// - The hardware reset input has a weak pull-up, so an open pin reads as inactive high.
// - Hardware reset touches only the flash die; the DRAM die keeps its state and operation.
// - The flash die holds the open-drain reset output low during its internal power-on reset.
// - After power-on reset the reset output stays low for a configured timeout, then is released.
// - When the reset output is released the flash die is at once idle and ready for transactions.
// - A flash program or erase continues after its select rises while the DRAM may be used.
// - Select one addresses flash, select two the DRAM; a falling select starts, a rising ends.
// - At the start of each transaction the strobe shows 1 for extra latency, 0 for none.
// - Reads drive the strobe edge-aligned with data; DRAM writes take the strobe as byte mask.
module ddmss_side #(
  parameter int unsigned LAT_CLKS = `DDMSS_LAT_CLKS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        link_ck,
  input  wire logic        flash_select_n,
  input  wire logic        dram_select_n,
  input  wire logic        hw_reset_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe_n,
  input  wire logic        rwds_in,
  output logic             rwds_out,
  output logic             rwds_oe_n,
  output logic             event_int_out,
  output logic             event_int_oe_n,
  output logic             por_reset_out_n,
  output logic             por_reset_oe_n,
  input  wire logic [15:0] por_timeout,
  input  wire logic        flash_busy,
  input  wire logic        flash_lat_req,
  input  wire logic        dram_lat_req,
  output logic      [47:0] ca_word,
  output logic             ca_valid,
  output logic             ca_die,
  input  wire logic [7:0]  rd_byte,
  output logic             rd_take,
  output logic      [7:0]  wr_byte,
  output logic             wr_mask,
  output logic             wr_valid,
  output logic             flash_ready
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (LAT_CLKS < 1 || LAT_CLKS > 63)
  begin : g_bad_lat
    $error("LAT_CLKS must lie in 1..63");
  end

  localparam logic [7:0] LAT_EDGES = 8'(2 * LAT_CLKS);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0]  ck_ff;
  logic [1:0]  fsel_ff;
  logic [1:0]  dsel_ff;
  logic [1:0]  hrst_ff;
  logic [7:0]  dq_s1_ff;
  logic [7:0]  dq_s2_ff;
  logic [1:0]  rwds_ff;

  // Two flops per pin; third ck flop only for edge finding
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ck_ff    <= 3'h0;
      fsel_ff  <= 2'h3;
      dsel_ff  <= 2'h3;
      hrst_ff  <= {2{`DDMSS_PIN_IDLE_HI}};  // Open pin reads high
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
      rwds_ff  <= 2'h0;
    end
    else if (clk_en)
    begin
      ck_ff    <= {ck_ff[1:0], link_ck};
      fsel_ff  <= {fsel_ff[0], flash_select_n};
      dsel_ff  <= {dsel_ff[0], dram_select_n};
      hrst_ff  <= {hrst_ff[0], hw_reset_n};
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      rwds_ff  <= {rwds_ff[0], rwds_in};
    end
  end

  // Synchronised levels and link clock edge (both edges, DDR)
  wire ck_edge  = ck_ff[2] ^ ck_ff[1];
  wire fsel_n   = fsel_ff[1];
  wire dsel_n   = dsel_ff[1];
  wire hrst_ok  = hrst_ff[1];
  wire rwds_s   = rwds_ff[1];

  // ************************************************************
  // Power-on reset output and its release delay
  // ************************************************************
  logic        por_cap_ff;
  logic [15:0] por_hold_ff;
  logic [15:0] por_cnt_ff;

  wire por_done = por_cap_ff && (por_cnt_ff == por_hold_ff);

  // Timeout caught after release, then counted out
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      por_cap_ff  <= 1'b0;
      por_hold_ff <= `DDMSS_POR_HOLD_DEF;
      por_cnt_ff  <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (!por_cap_ff)
      begin
        por_cap_ff  <= 1'b1;
        por_hold_ff <= por_timeout;
      end
      else if (!por_done)
      begin
        por_cnt_ff <= por_cnt_ff + 16'h0001;
      end
    end
  end

  // Driven low until the delay ends, then released
  assign por_reset_out_n = 1'b0;
  assign por_reset_oe_n  = por_done;
  assign flash_ready     = por_done;

  // ************************************************************
  // Event output
  // ************************************************************
  logic busy_d_ff;
  logic event_ff;
  wire  state_is_idle;
  wire  busy_fell  = busy_d_ff && !flash_busy;
  wire  event_clr  = fsel_n == 1'b0 && state_is_idle;

  // Sticky event, set wins over the clear at a new flash select
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_d_ff <= 1'b0;
      event_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      busy_d_ff <= flash_busy;
      if (busy_fell)
        event_ff <= 1'b1;
      else if (event_clr || !hrst_ok)
        event_ff <= 1'b0;
    end
  end

  // Open-drain: only ever pulls low
  assign event_int_out  = 1'b0;
  assign event_int_oe_n = !event_ff;

  // ************************************************************
  // Transaction sequencer
  // ************************************************************
  ddmss_pkg::ddmss_state_t state_ff;
  ddmss_pkg::ddmss_die_t   die_ff;
  logic [2:0]  ca_cnt_ff;
  logic [47:0] ca_ff;
  logic        lat_flag_ff;
  logic [7:0]  lat_cnt_ff;
  logic        rd_ff;
  logic [7:0]  dq_ff;
  logic        rwds_ff_o;
  logic        ca_valid_ff;
  logic [7:0]  wr_byte_ff;
  logic        wr_mask_ff;
  logic        wr_valid_ff;

  assign state_is_idle = state_ff == ddmss_pkg::ST_IDLE;
  wire is_flash   = die_ff == ddmss_pkg::DIE_FLASH;
  wire start_fl   = !fsel_n && por_done && hrst_ok;
  wire start_dr   = !dsel_n && fsel_n;
  wire cur_sel_n  = is_flash ? fsel_n : dsel_n;
  wire fl_abort   = is_flash && !hrst_ok;
  wire lat_need   = start_fl ? flash_lat_req : dram_lat_req;
  wire [7:0] lat_total = lat_flag_ff ? 8'(LAT_EDGES << 1) : LAT_EDGES;
  wire in_read    = state_ff == ddmss_pkg::ST_DATA && rd_ff;

  // State, die and counters
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff    <= ddmss_pkg::ST_IDLE;
      die_ff      <= ddmss_pkg::DIE_FLASH;
      ca_cnt_ff   <= 3'h0;
      ca_ff       <= 48'h0;
      lat_flag_ff <= 1'b0;
      lat_cnt_ff  <= 8'h00;
      rd_ff       <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state_ff)
        ddmss_pkg::ST_IDLE:
        begin
          if (start_fl || start_dr)
          begin
            state_ff    <= ddmss_pkg::ST_CA;
            die_ff      <= start_fl ? ddmss_pkg::DIE_FLASH : ddmss_pkg::DIE_DRAM;
            lat_flag_ff <= lat_need;
            ca_cnt_ff   <= 3'h0;
            lat_cnt_ff  <= 8'h00;
          end
        end
        ddmss_pkg::ST_CA:
        begin
          if (ck_edge)
          begin
            ca_ff     <= {ca_ff[39:0], dq_s2_ff};
            ca_cnt_ff <= ca_cnt_ff + 3'h1;
            if (ca_cnt_ff == `DDMSS_CA_BYTES - 3'h1)
              state_ff <= ddmss_pkg::ST_LAT;
          end
        end
        ddmss_pkg::ST_LAT:
        begin
          rd_ff <= ca_ff[`DDMSS_CA_RD_BIT];
          if (ck_edge)
          begin
            lat_cnt_ff <= lat_cnt_ff + 8'h01;
            if (lat_cnt_ff == lat_total - 8'h01)
              state_ff <= ddmss_pkg::ST_DATA;
          end
        end
        ddmss_pkg::ST_DATA:
        begin
          state_ff <= ddmss_pkg::ST_DATA;
        end
        default:
        begin
          state_ff <= ddmss_pkg::ST_IDLE;
        end
      endcase
      // Rising select or flash reset ends the transaction
      if (!state_is_idle && (cur_sel_n || fl_abort))
        state_ff <= ddmss_pkg::ST_IDLE;
    end
  end

  // Data path and strobe registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dq_ff       <= 8'h00;
      rwds_ff_o   <= 1'b0;
      ca_valid_ff <= 1'b0;
      wr_byte_ff  <= 8'h00;
      wr_mask_ff  <= 1'b0;
      wr_valid_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      ca_valid_ff <= state_ff == ddmss_pkg::ST_CA && ck_edge
                     && ca_cnt_ff == `DDMSS_CA_BYTES - 3'h1;
      wr_valid_ff <= state_ff == ddmss_pkg::ST_DATA && !rd_ff && ck_edge && !cur_sel_n;
      if (state_ff != ddmss_pkg::ST_DATA)
        rwds_ff_o <= (state_ff == ddmss_pkg::ST_LAT) ? 1'b0 : lat_need;
      else if (in_read && ck_edge)
      begin
        dq_ff     <= rd_byte;
        rwds_ff_o <= !rwds_ff_o;
      end
      else if (!rd_ff && ck_edge)
      begin
        wr_byte_ff <= dq_s2_ff;
        wr_mask_ff <= !is_flash && rwds_s;
      end
    end
  end

  // Strobe shows latency flag during the address phase
  wire rwds_lat = state_ff == ddmss_pkg::ST_CA;
  // Hardware reset silences the flash die only; the DRAM keeps driving
  wire die_live = hrst_ok || !is_flash;
  assign rwds_out  = rwds_lat ? lat_flag_ff : rwds_ff_o;
  assign rwds_oe_n = !(die_live && (rwds_lat || in_read));
  assign dq_out    = dq_ff;
  assign dq_oe_n   = !(die_live && in_read);
  assign rd_take   = clk_en && in_read && ck_edge && !cur_sel_n;
  assign ca_word   = ca_ff;
  assign ca_valid  = ca_valid_ff;
  assign ca_die    = die_ff;
  assign wr_byte   = wr_byte_ff;
  assign wr_mask   = wr_mask_ff;
  assign wr_valid  = wr_valid_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Enabled cycles since the timeout was captured, saturating
  logic [16:0] por_age_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      por_age_ff <= 17'h00000;
    else if (clk_en && por_cap_ff && !por_age_ff[16])
      por_age_ff <= por_age_ff + 17'h00001;
  end

  sequence s_read_edge;
    clk_en && in_read && ck_edge;
  endsequence

  sequence s_flash_reset_hit;
    clk_en && !state_is_idle && is_flash && !hrst_ok;
  endsequence

  AST_DQ_HIZ_IN_RESET: assert property (!hrst_ok && (is_flash || state_is_idle)
                                        |-> dq_oe_n && rwds_oe_n)
    else $error("data or strobe driven during hardware reset");
  AST_EVENT_OPEN_DRAIN: assert property (!event_int_oe_n |-> event_int_out == 1'b0)
    else $error("event output driven high");
  AST_EVENT_ON_READY: assert property (clk_en && busy_fell |=> !event_int_oe_n)
    else $error("busy-to-ready did not raise the event");
  AST_POR_HELD: assert property (!por_cap_ff || por_age_ff < {1'b0, por_hold_ff}
                                 |-> !por_reset_oe_n && !flash_ready)
    else $error("reset output released early");
  AST_POR_TIMEOUT: assert property ($rose(por_reset_oe_n)
                                    |-> por_age_ff == {1'b0, por_hold_ff})
    else $error("reset output released before the timeout");
  AST_IDLE_AT_RELEASE: assert property ($rose(flash_ready) |-> !(is_flash && !state_is_idle))
    else $error("flash not idle at reset release");
  AST_FLASH_ABORT: assert property (s_flash_reset_hit |=> state_is_idle)
    else $error("flash transaction survived hardware reset");
  AST_DRAM_KEEPS: assert property (clk_en && !is_flash && !dsel_n && !hrst_ok
                                   && !state_is_idle |=> !state_is_idle)
    else $error("hardware reset disturbed the DRAM transaction");
  AST_SEL_END: assert property (clk_en && !state_is_idle && cur_sel_n |=> state_is_idle)
    else $error("transaction outlived its select");
  AST_LAT_FLAG: assert property (clk_en && state_is_idle && (start_fl || start_dr)
                                 |=> state_ff == ddmss_pkg::ST_CA
                                     && rwds_out == $past(lat_need))
    else $error("strobe does not show the latency flag");
  AST_READ_STROBE: assert property (s_read_edge |=> rwds_out != $past(rwds_out))
    else $error("read strobe not toggled with data");

endmodule : ddmss_side

//--- test/ddmss_host_model.sv
// Host memory controller model that drives the shared link
`timescale 1ns/1ps
module ddmss_host_model #(
  parameter int LAT = 2
) (
  input  wire logic       clk,
  input  wire logic [7:0] dq_pin,
  input  wire logic       rwds_pin,
  output logic            link_ck,
  output logic            flash_select_n,
  output logic            dram_select_n,
  output logic      [7:0] dq_drv,
  output logic            rwds_drv
);
  logic drive_ff;
  logic mask_ff;

  // Idle levels: link clock low, both selects high
  initial
  begin
    {link_ck, flash_select_n, dram_select_n} = 3'h3;
    {dq_drv, rwds_drv, drive_ff, mask_ff} = 11'h000;
  end

  // Released lines show a pattern that changes every cycle
  always @(posedge clk)
  begin
    if (!drive_ff)
      dq_drv <= ~dq_drv;
    if (!mask_ff)
      rwds_drv <= ~rwds_drv;
  end

  // ****************************************
  // One whole transaction, one byte per link edge
  // ****************************************
  task automatic xfer(input logic to_dram, input logic [47:0] ca, input int n,
                      input logic [7:0] wbase, output logic flag);
    int lat_edges;
    @(posedge clk);
    flash_select_n <= to_dram;
    dram_select_n  <= !to_dram;
    drive_ff       <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      repeat (2) @(posedge clk);
      dq_drv <= ca[47 - 8 * i -: 8];
      repeat (2) @(posedge clk);
      if (i == 0)
        flag = rwds_pin;
      link_ck <= ~link_ck;
    end
    lat_edges = flag ? 4 * LAT : 2 * LAT;
    drive_ff  <= !ca[47];
    mask_ff   <= to_dram && !ca[47];
    repeat (lat_edges)
    begin
      repeat (4) @(posedge clk);
      link_ck <= ~link_ck;
    end
    for (int i = 0; i < n; i++)
    begin
      repeat (2) @(posedge clk);
      if (!ca[47])
        dq_drv <= wbase + 8'(i);
      if (mask_ff)
        rwds_drv <= i[0];
      repeat (2) @(posedge clk);
      link_ck <= ~link_ck;
    end
    repeat (4) @(posedge clk);
    {flash_select_n, dram_select_n} <= 2'h3;
    drive_ff <= 1'b0;
    mask_ff  <= 1'b0;
  endtask : xfer
endmodule : ddmss_host_model

//--- test/ddmss_side_tb.sv
// Self-checking bench for the side-signal block
`timescale 1ns/1ps
module ddmss_side_tb;
  localparam int          LAT   = 2;
  localparam logic [15:0] POR_T = 16'h0020;
  logic        clk, arst_n, hw_en, hw_drv, flash_busy, flash_lat_req, dram_lat_req;
  logic        link_ck, flash_select_n, dram_select_n, dq_oe_n, rwds_out, rwds_oe_n;
  logic        rwds_drv, rwds_pin, event_int_out, event_int_oe_n, por_reset_out_n;
  logic        por_reset_oe_n, ca_valid, ca_die, cap_die, rd_take, wr_mask, wr_valid;
  logic        flash_ready, rwds_prev, flag;
  logic [7:0]  rd_byte, dq_out, dq_drv, dq_pin, wr_byte;
  logic [47:0] ca_word, cap_ca;
  logic [8:0]  wq[$];
  logic [7:0]  rq[$];
  int          mismatches, checks_done, cyc;
  tri1         hw_pin;

  // Pin levels: open-drain outputs pulled up, shared lines resolved
  wire event_pin = event_int_oe_n ? 1'b1 : event_int_out;
  wire por_pin   = por_reset_oe_n ? 1'b1 : por_reset_out_n;
  assign hw_pin   = hw_en ? hw_drv : 1'bz;
  assign dq_pin   = dq_oe_n ? dq_drv : dq_out;
  assign rwds_pin = rwds_oe_n ? rwds_drv : rwds_out;

  ddmss_side #(.LAT_CLKS(LAT)) u_ddmss_side (
    .clk, .arst_n, .clk_en(1'b1), .link_ck, .flash_select_n, .dram_select_n,
    .hw_reset_n(hw_pin), .dq_in(dq_pin), .dq_out, .dq_oe_n, .rwds_in(rwds_pin),
    .rwds_out, .rwds_oe_n, .event_int_out, .event_int_oe_n, .por_reset_out_n,
    .por_reset_oe_n, .por_timeout(POR_T), .flash_busy, .flash_lat_req, .dram_lat_req,
    .ca_word, .ca_valid, .ca_die, .rd_byte, .rd_take, .wr_byte, .wr_mask, .wr_valid,
    .flash_ready
  );

  ddmss_host_model #(.LAT(LAT)) u_host (
    .clk, .dq_pin, .rwds_pin, .link_ck, .flash_select_n, .dram_select_n, .dq_drv,
    .rwds_drv
  );

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Die-side data source, captures and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ca_valid)
      {cap_ca, cap_die} <= {ca_word, ca_die};
    if (wr_valid)
      wq.push_back({wr_mask, wr_byte});
    if (rd_take)
      rd_byte <= rd_byte + 8'h01;
    if (!dq_oe_n && !rwds_oe_n && rwds_out !== rwds_prev)
      rq.push_back(dq_pin);
    rwds_prev <= rwds_out;
    if (cyc == 8000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************
  // Compare, verdict and shared transaction check
  // ****************************************
  task automatic chk_val(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic run(input logic to_dram, input logic [47:0] ca, input int n, input logic ef);
    logic [7:0] base;
    base = rd_byte;
    rq.delete();
    wq.delete();
    u_host.xfer(to_dram, ca, n, 8'hc0, flag);
    repeat (4) @(posedge clk);
    chk_val("latency flag", ef, flag);
    chk_val("ca word", ca, cap_ca);
    chk_val("die", to_dram, cap_die);
    chk_val("bytes", 48'(n), 48'(ca[47] ? rq.size() : wq.size()));
    for (int i = 0; i < rq.size(); i++)
      chk_val("read byte", base + 8'(i), rq[i]);
    for (int i = 0; i < wq.size(); i++)
      chk_val("write byte", {to_dram & i[0], 8'hc0 + 8'(i)}, wq[i]);
  endtask : run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_por();
    int n;
    n = 0;
    chk_val("reset out early", 0, por_pin);
    chk_val("ready early", 0, flash_ready);
    while (por_reset_oe_n !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk_val("release edge", 48'(POR_T) + 2, 48'(n));
    chk_val("reset out pin", 1, por_pin);
    chk_val("ready", 1, flash_ready);
  endtask : t_por

  task automatic t_busy_dram();
    flash_lat_req <= 1'b1;
    run(1'b0, 48'h8000_0012_0003, 6, 1'b1);
    run(1'b0, 48'h0000_0055_0002, 2, 1'b1);
    flash_busy   <= 1'b1;
    dram_lat_req <= 1'b1;
    run(1'b1, 48'hc000_0034_0001, 4, 1'b1);
    chk_val("event idle", 1, event_pin);
    dram_lat_req <= 1'b0;
    run(1'b1, 48'h2000_0036_0005, 4, 1'b0);
    flash_busy <= 1'b0;
    repeat (3) @(posedge clk);
    chk_val("event low", 0, event_pin);
    chk_val("event value", 0, event_int_out);
  endtask : t_busy_dram

  task automatic t_hw_reset();
    logic f;
    fork
      u_host.xfer(1'b0, 48'h8000_0077_0000, 8, 8'h00, f);
      begin
        repeat (600)
        begin
          @(posedge clk);
          if (dq_oe_n === 1'b0)
            break;
        end
        hw_en  <= 1'b1;
        hw_drv <= 1'b0;
        repeat (5) @(posedge clk);
        chk_val("dq released", 1, dq_oe_n);
        chk_val("strobe released", 1, rwds_oe_n);
        chk_val("event cleared", 1, event_pin);
      end
    join
    run(1'b1, 48'h0000_0099_0004, 2, 1'b0);
    hw_en <= 1'b0;
    repeat (5) @(posedge clk);
    run(1'b0, 48'h8000_00aa_0000, 2, 1'b1);
  endtask : t_hw_reset

  // Main sequence
  initial
  begin
    {arst_n, hw_en, hw_drv, flash_busy, flash_lat_req, dram_lat_req} = 6'h04;
    {rd_byte, rwds_prev} = 9'h0b4;
    {mismatches, checks_done, cyc} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_por();
    t_busy_dram();
    t_hw_reset();
    give_verdict();
  end
endmodule : ddmss_side_tb
